/* File: gpfc_board_model.sv */
// Board circuitry that hangs on the fifth and sixth general-purpose pins.
`timescale 1ns/1ps
module gpfc_board_model (
	input wire logic clk,
	input wire logic pin5_o,
	input wire logic pin5_oe_n,
	input wire logic pin6_o,
	input wire logic pin6_oe_n,
	input wire logic pin6_pullup_en,
	input wire logic pin6_pulldown_en,
	input wire logic ext5_en,
	input wire logic ext5_val,
	input wire logic ext6_en,
	input wire logic ext6_val,
	output logic pin5_i,
	output logic pin6_i
);
	logic float_q = 1'b0;

	// An undriven pin without a pull wanders, so it toggles instead of holding a level.
	always @(posedge clk) begin
		float_q <= ~float_q;
	end

	// The codec wins while it drives, then the board source, then pulls or floating.
	assign pin5_i = !pin5_oe_n ? pin5_o : ext5_en ? ext5_val : float_q;
	assign pin6_i = !pin6_oe_n ? pin6_o : ext6_en ? ext6_val :
		pin6_pullup_en ? 1'b1 : pin6_pulldown_en ? 1'b0 : float_q;
endmodule

/* File: gpfc_consts.svh */
// Offsets, field positions, reset values and function codes of the pin control block.
`ifndef GPFC_CONSTS_SVH
`define GPFC_CONSTS_SVH

`define GPFC_ADDR_W 12
`define GPFC_IDX_PIN5 12'h204
`define GPFC_IDX_PIN6 12'h205
`define GPFC_IDX_CTRL 12'h206
`define GPFC_OFS_PIN5 12'h810
`define GPFC_OFS_PIN6 12'h814
`define GPFC_OFS_CTRL 12'h818
`define GPFC_RST_PIN5 16'h8000
`define GPFC_RST_PIN6 16'h8000
`define GPFC_WMASK_PIN5 16'h845F
`define GPFC_WMASK_PIN6 16'hE400
`define GPFC_BIT_DIR 15
`define GPFC_BIT_PU 14
`define GPFC_BIT_PD 13
`define GPFC_BIT_POL 10
`define GPFC_BIT_LVL 6
`define GPFC_FN_HI 4
`define GPFC_BIT_OVR 0
`define GPFC_BIT_P6IN 1
`define GPFC_RESP_OKAY 2'h0
`define GPFC_RESP_SLVERR 2'h2
`define GPFC_FN_UNUSED 5'h00
`define GPFC_FN_STATIC 5'h01
`define GPFC_FN_SER_DATA 5'h02
`define GPFC_FN_IRQ 5'h03
`define GPFC_FN_TEMP 5'h04
`define GPFC_FN_PLL2 5'h06
`define GPFC_FN_PLL3 5'h07
`define GPFC_FN_FLL 5'h09
`define GPFC_FN_RANGE_ACT 5'h0A
`define GPFC_FN_WSEQ 5'h0B
`define GPFC_FN_LVL_GATE 5'h0C
`define GPFC_FN_LVL_PEAK 5'h0D
`define GPFC_FN_LVL_SAT 5'h0E
`define GPFC_FN_LVL_THR 5'h0F
`define GPFC_FN_LVL_LOCK 5'h10
`define GPFC_FN_FIFO 5'h11
`define GPFC_FN_DIV_CLK 5'h12
`define GPFC_FN_RSV_LO 5'h17

`endif

/* File: gpfc_func_mux.sv */
// Function select decoder that picks the level for the fifth pin.
`timescale 1ns/1ps
`include "gpfc_consts.svh"
module gpfc_func_mux import gpfc_pkg::*; (
	input wire logic [4:0] pin5_function_select,
	input wire logic pin5_level_bit,
	input wire logic pin5_polarity,
	input wire gpfc_stat_s stat,
	output logic drive_val
);
	logic routed;

	// Routed flags follow their live value; unmapped codes drive a quiet low.
	always_comb begin
		routed = 1'b0;
		case (pin5_function_select)
			`GPFC_FN_SER_DATA: routed = stat.serial_audio_data_out;
			`GPFC_FN_IRQ: routed = stat.irq;
			`GPFC_FN_TEMP: routed = stat.temp_shutdown;
			`GPFC_FN_PLL2: routed = stat.pll2_lock;
			`GPFC_FN_PLL3: routed = stat.pll3_lock;
			`GPFC_FN_FLL: routed = stat.fll_lock;
			`GPFC_FN_RANGE_ACT: routed = stat.dynamic_range_controller_active;
			`GPFC_FN_WSEQ: routed = stat.write_seq_done;
			`GPFC_FN_LVL_GATE: routed = stat.automatic_level_control_noise_gate;
			`GPFC_FN_LVL_PEAK: routed = stat.automatic_level_control_peak_limit;
			`GPFC_FN_LVL_SAT: routed = stat.automatic_level_control_saturation;
			`GPFC_FN_LVL_THR: routed = stat.automatic_level_control_threshold;
			`GPFC_FN_LVL_LOCK: routed = stat.automatic_level_control_lock;
			`GPFC_FN_FIFO: routed = stat.fifo_error;
			`GPFC_FN_DIV_CLK: routed = stat.divided_output_clock;
			default: routed = 1'b0;
		endcase
	end

	// Unused and static codes bypass the polarity stage; everything routed is inverted on request.
	always_comb begin
		if (pin5_function_select == `GPFC_FN_STATIC) begin
			drive_val = pin5_level_bit;
		end else if (pin5_function_select == `GPFC_FN_UNUSED) begin
			drive_val = 1'b0;
		end else begin
			drive_val = routed ^ (pin5_polarity & routed_valid(pin5_function_select));
		end
	end

	// Reserved codes must stay low even with polarity set.
	function automatic logic routed_valid(input logic [4:0] fn);
		routed_valid = (fn <= `GPFC_FN_DIV_CLK) && (fn != 5'h05) && (fn != 5'h08);
	endfunction
endmodule

/* File: gpfc_pin_drv.sv */
// Output register stage of one general-purpose pin.
`timescale 1ns/1ps
module gpfc_pin_drv (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic drive_val,
	input wire logic drive_oe_n,
	output logic pin_o,
	output logic pin_oe_n
);
	// Registered so the pad sees no decode glitches; the pin starts released.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_o <= 1'b0;
			pin_oe_n <= 1'b1;
		end else begin
			pin_o <= drive_val;
			pin_oe_n <= drive_oe_n;
		end
	end
endmodule

/* File: gpfc_pkg.sv */
// Types shared by the pin control block.
package gpfc_pkg;

	// Internal status and clock signals that can be routed to the fifth pin.
	typedef struct packed {
		logic serial_audio_data_out;
		logic irq;
		logic temp_shutdown;
		logic pll2_lock;
		logic pll3_lock;
		logic fll_lock;
		logic dynamic_range_controller_active;
		logic write_seq_done;
		logic automatic_level_control_noise_gate;
		logic automatic_level_control_peak_limit;
		logic automatic_level_control_saturation;
		logic automatic_level_control_threshold;
		logic automatic_level_control_lock;
		logic fifo_error;
		logic divided_output_clock;
	} gpfc_stat_s;

	typedef enum logic {GPFC_WR_IDLE, GPFC_WR_RESP} gpfc_wr_e;
	typedef enum logic {GPFC_RD_IDLE, GPFC_RD_DATA} gpfc_rd_e;

	// Whole state of the register slave.
	typedef struct packed {
		gpfc_wr_e wr_st;
		gpfc_rd_e rd_st;
		logic aw_have;
		logic w_have;
		logic [11:0] awaddr;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		logic [1:0] bresp;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] pin5_ctrl;
		logic [15:0] pin6_ctrl;
		logic clock_regulator_override;
	} gpfc_state_s;

endpackage

/* File: gpfc_top.sv */
// Pin function control for two general-purpose pins behind an AXI4-Lite slave.
`timescale 1ns/1ps
`include "gpfc_consts.svh"
module gpfc_top import gpfc_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire gpfc_stat_s stat,
	input wire logic pin5_i,
	output logic pin5_o,
	output logic pin5_oe_n,
	input wire logic pin6_i,
	output logic pin6_o,
	output logic pin6_oe_n,
	output logic pin6_pullup_en,
	output logic pin6_pulldown_en
);
	gpfc_state_s state_reg;
	gpfc_state_s state_next;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic pin5_drive;
	logic [1:0] drive_val_w;
	logic [1:0] drive_oe_n_w;
	logic [1:0] pin_o_w;
	logic [1:0] pin_oe_n_w;
	logic pin6_in_level;

	////////////////////////////////////////////////////////////////////////////
	// Bus handshakes.

	// Address and data are taken independently and held until both are present.
	assign s_axi_awready = (state_reg.wr_st == GPFC_WR_IDLE) && !state_reg.aw_have;
	assign s_axi_wready = (state_reg.wr_st == GPFC_WR_IDLE) && !state_reg.w_have;
	assign s_axi_arready = (state_reg.rd_st == GPFC_RD_IDLE);
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign ar_take = s_axi_arvalid && s_axi_arready;

	// Answers come straight from the state register.
	assign s_axi_bvalid = (state_reg.wr_st == GPFC_WR_RESP);
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_rvalid = (state_reg.rd_st == GPFC_RD_DATA);
	assign s_axi_rdata = state_reg.rdata;
	assign s_axi_rresp = state_reg.rresp;

	// The sixth pin input after its polarity stage.
	assign pin6_in_level = pin6_i ^ state_reg.pin6_ctrl[`GPFC_BIT_POL];

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Merges a 16-bit write into a register under byte strobes and a writable mask.
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] strb, input logic [15:0] mask);
		logic [15:0] lane;
		lane = {{8{strb[1]}}, {8{strb[0]}}} & mask;
		merge16 = (old & ~lane) | (wd & lane);
	endfunction

	// One process computes the whole next state, so write and read share one view; reset is applied in the state register.
	always_comb begin
		state_next = state_reg;
		// Latch address and data whichever arrives first.
		if (aw_take) begin
			state_next.aw_have = 1'b1;
			state_next.awaddr = s_axi_awaddr;
		end
		if (w_take) begin
			state_next.w_have = 1'b1;
			state_next.wdata = s_axi_wdata[15:0];
			state_next.wstrb = s_axi_wstrb[1:0];
		end
		// Perform the write once both halves are in.
		if ((state_reg.wr_st == GPFC_WR_IDLE) && state_reg.aw_have && state_reg.w_have) begin
			state_next.aw_have = 1'b0;
			state_next.w_have = 1'b0;
			state_next.wr_st = GPFC_WR_RESP;
			state_next.bresp = `GPFC_RESP_OKAY;
			case (state_reg.awaddr)
				`GPFC_OFS_PIN5: begin
					// Function select, level, polarity and direction all steer the pin.
					state_next.pin5_ctrl = merge16(state_reg.pin5_ctrl, state_reg.wdata,
						state_reg.wstrb, `GPFC_WMASK_PIN5);
				end
				`GPFC_OFS_PIN6: begin
					state_next.pin6_ctrl = merge16(state_reg.pin6_ctrl, state_reg.wdata,
						state_reg.wstrb, `GPFC_WMASK_PIN6);
				end
				`GPFC_OFS_CTRL: begin
					if (state_reg.wstrb[0]) begin
						state_next.clock_regulator_override = state_reg.wdata[`GPFC_BIT_OVR];
					end
				end
				default: begin
					state_next.bresp = `GPFC_RESP_SLVERR;
				end
			endcase
		end
		// Write response retires on bready.
		if ((state_reg.wr_st == GPFC_WR_RESP) && s_axi_bready) begin
			state_next.wr_st = GPFC_WR_IDLE;
		end
		// Read data are captured at the address handshake.
		if (ar_take) begin
			state_next.rd_st = GPFC_RD_DATA;
			state_next.rresp = `GPFC_RESP_OKAY;
			state_next.rdata = 32'h0000_0000;
			case (s_axi_araddr)
				`GPFC_OFS_PIN5: begin
					state_next.rdata[15:0] = state_reg.pin5_ctrl;
					// The level bit reads the pin, not the stored value. With the pin
					// driven this just echoes the pad and software must not rely on it.
					state_next.rdata[`GPFC_BIT_LVL] = pin5_i;
				end
				`GPFC_OFS_PIN6: begin
					state_next.rdata[15:0] = state_reg.pin6_ctrl;
				end
				`GPFC_OFS_CTRL: begin
					state_next.rdata[`GPFC_BIT_OVR] = state_reg.clock_regulator_override;
					state_next.rdata[`GPFC_BIT_P6IN] = pin6_in_level;
				end
				default: begin
					state_next.rresp = `GPFC_RESP_SLVERR;
				end
			endcase
		end
		if ((state_reg.rd_st == GPFC_RD_DATA) && s_axi_rready) begin
			state_next.rd_st = GPFC_RD_IDLE;
		end
	end

	// State register; both pins start as inputs with pulls off.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg.wr_st <= GPFC_WR_IDLE;
			state_reg.rd_st <= GPFC_RD_IDLE;
			state_reg.aw_have <= 1'b0;
			state_reg.w_have <= 1'b0;
			state_reg.awaddr <= 12'h000;
			state_reg.wdata <= 16'h0000;
			state_reg.wstrb <= 2'h0;
			state_reg.bresp <= 2'h0;
			state_reg.rdata <= 32'h0000_0000;
			state_reg.rresp <= 2'h0;
			state_reg.pin5_ctrl <= `GPFC_RST_PIN5;
			state_reg.pin6_ctrl <= `GPFC_RST_PIN6;
			state_reg.clock_regulator_override <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin datapath.

	gpfc_func_mux u_func_mux (
		.pin5_function_select(state_reg.pin5_ctrl[`GPFC_FN_HI:0]),
		.pin5_level_bit(state_reg.pin5_ctrl[`GPFC_BIT_LVL]),
		.pin5_polarity(state_reg.pin5_ctrl[`GPFC_BIT_POL]),
		.stat(stat),
		.drive_val(pin5_drive)
	);

	// The sixth pin has no function routing here, so it drives low through its polarity.
	assign drive_val_w[0] = pin5_drive;
	assign drive_val_w[1] = 1'b0 ^ state_reg.pin6_ctrl[`GPFC_BIT_POL];
	assign drive_oe_n_w[0] = state_reg.pin5_ctrl[`GPFC_BIT_DIR];
	assign drive_oe_n_w[1] = state_reg.pin6_ctrl[`GPFC_BIT_DIR];

	// One output stage per pin.
	for (genvar gi = 0; gi < 2; gi++) begin : g_pin
		gpfc_pin_drv u_pin_drv (
			.clk(clk),
			.arst_n(arst_n),
			.drive_val(drive_val_w[gi]),
			.drive_oe_n(drive_oe_n_w[gi]),
			.pin_o(pin_o_w[gi]),
			.pin_oe_n(pin_oe_n_w[gi])
		);
	end

	assign pin5_o = pin_o_w[0];
	assign pin5_oe_n = pin_oe_n_w[0];
	assign pin6_o = pin_o_w[1];
	assign pin6_oe_n = pin_oe_n_w[1];

	// Pull controls come straight from register flops, so they are glitch free.
	assign pin6_pullup_en = state_reg.pin6_ctrl[`GPFC_BIT_PU];
	assign pin6_pulldown_en = state_reg.pin6_ctrl[`GPFC_BIT_PD];

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	logic [4:0] fn_now;
	logic pol_now;
	logic write_go;
	assign fn_now = state_reg.pin5_ctrl[`GPFC_FN_HI:0];
	assign pol_now = state_reg.pin5_ctrl[`GPFC_BIT_POL];
	// Kept as a plain signal so that it can also be used inside $past.
	assign write_go = (state_reg.wr_st == GPFC_WR_IDLE) && state_reg.aw_have &&
		state_reg.w_have;

	// A read of the fifth pin register: the address handshake alone.
	sequence s_pin5_read;
		ar_take && (s_axi_araddr == `GPFC_OFS_PIN5);
	endsequence

	// A write whose halves are both latched.
	sequence s_write_ready;
		write_go;
	endsequence

	a_static_level_out: assert property (
		(fn_now == `GPFC_FN_STATIC) |=> (pin5_o == $past(state_reg.pin5_ctrl[`GPFC_BIT_LVL])))
		else $error("static level not driven on fifth pin");

	a_level_readback: assert property (
		s_pin5_read |=> s_axi_rvalid && (s_axi_rdata[`GPFC_BIT_LVL] == $past(pin5_i)))
		else $error("level bit readback does not match pin input");

	a_output_dir_drive: assert property (
		(state_reg.pin5_ctrl[`GPFC_BIT_DIR] == 1'b0) |=> (pin5_oe_n == 1'b0))
		else $error("fifth pin not driven in output direction");

	a_unused_code_low: assert property (
		(fn_now == `GPFC_FN_UNUSED) |=> (pin5_o == 1'b0))
		else $error("unused function code drives the pin");

	a_irq_route: assert property (
		(fn_now == `GPFC_FN_IRQ) |=> (pin5_o == $past(stat.irq ^ pol_now)))
		else $error("interrupt not routed to fifth pin");

	a_temp_route: assert property (
		(fn_now == `GPFC_FN_TEMP) |=> (pin5_o == $past(stat.temp_shutdown ^ pol_now)))
		else $error("temperature shutdown not routed");

	a_wseq_route: assert property (
		(fn_now == `GPFC_FN_WSEQ) |=> (pin5_o == $past(stat.write_seq_done ^ pol_now)))
		else $error("sequencer done not routed");

	a_lvl_lock_route: assert property (
		(fn_now == `GPFC_FN_LVL_LOCK) |=>
		(pin5_o == $past(stat.automatic_level_control_lock ^ pol_now)))
		else $error("level lock flag not routed");

	a_reserved_quiet: assert property (
		(fn_now >= `GPFC_FN_RSV_LO) [*2] |-> (pin5_o == 1'b0))
		else $error("reserved code drives the pin");

	a_pin6_direction: assert property (
		##1 (pin6_oe_n == $past(state_reg.pin6_ctrl[`GPFC_BIT_DIR])))
		else $error("sixth pin enable does not follow direction bit");

	a_pin6_pulls: assert property (
		$rose(state_reg.pin6_ctrl[`GPFC_BIT_PU]) |-> pin6_pullup_en && $past(write_go))
		else $error("pull-up enable not tied to a register write");

	a_pin6_pulldown: assert property (
		$changed(pin6_pulldown_en) |-> $past(write_go)
		&& ($past(state_reg.awaddr) == `GPFC_OFS_PIN6))
		else $error("pull-down changed without a sixth pin write");

	a_pin6_polarity: assert property (
		(state_reg.pin6_ctrl[`GPFC_BIT_DIR] == 1'b0) [*2] |->
		(pin6_o == $past(state_reg.pin6_ctrl[`GPFC_BIT_POL])))
		else $error("sixth pin polarity not applied");

	a_flag_polarity: assert property (
		(fn_now == `GPFC_FN_FLL) && pol_now |=> (pin5_o == !$past(stat.fll_lock)))
		else $error("inverted routed flag does not follow live value");

	a_write_answer: assert property (
		s_write_ready |=> s_axi_bvalid)
		else $error("write response not raised after both halves");

	// An unmapped write still gets an answer, so a stray address cannot hang the master.
	a_write_unmapped: assert property (
		s_write_ready ##0
		!(state_reg.awaddr inside {`GPFC_OFS_PIN5, `GPFC_OFS_PIN6, `GPFC_OFS_CTRL}) |=>
		(s_axi_bresp == `GPFC_RESP_SLVERR))
		else $error("unmapped write not answered with an error");

	a_read_answer: assert property (
		ar_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data not presented one cycle after the address");

	a_pin5_released: assert property (
		(state_reg.pin5_ctrl[`GPFC_BIT_DIR] == 1'b1) |=> (pin5_oe_n == 1'b1))
		else $error("fifth pin driven in input direction");

	a_sdata_route: assert property (
		(fn_now == `GPFC_FN_SER_DATA) |=>
		(pin5_o == $past(stat.serial_audio_data_out ^ pol_now)))
		else $error("serial audio data not routed to fifth pin");

	a_pll2_route: assert property (
		(fn_now == `GPFC_FN_PLL2) |=>
		(pin5_o == $past(stat.pll2_lock ^ pol_now)))
		else $error("second loop lock not routed");

	a_range_route: assert property (
		(fn_now == `GPFC_FN_RANGE_ACT) |=>
		(pin5_o == $past(stat.dynamic_range_controller_active ^ pol_now)))
		else $error("range controller activity not routed");

	a_gate_route: assert property (
		(fn_now == `GPFC_FN_LVL_GATE) |=>
		(pin5_o == $past(stat.automatic_level_control_noise_gate ^ pol_now)))
		else $error("noise gate flag not routed");

	a_fifo_route: assert property (
		(fn_now == `GPFC_FN_FIFO) |=>
		(pin5_o == $past(stat.fifo_error ^ pol_now)))
		else $error("fifo error flag not routed");

	a_divclk_route: assert property (
		(fn_now == `GPFC_FN_DIV_CLK) |=>
		(pin5_o == $past(stat.divided_output_clock ^ pol_now)))
		else $error("divided clock not routed");
endmodule

/* File: gpfc_top_tb.sv */
// Self-checking bench for the two-pin function control block.
`timescale 1ns/1ps
`include "gpfc_consts.svh"
module gpfc_top_tb import gpfc_pkg::*;;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	gpfc_stat_s stat = '0;
	logic pin5_i, pin5_o, pin5_oe_n, pin6_i, pin6_o, pin6_oe_n, pu_en, pd_en;
	logic e5_en = 1'b1, e5_v = 1'b0, e6_en = 1'b1, e6_v = 1'b0;
	int fails = 0;
	int total_checks = 0;
	integer seed = 32'h441230DF;

	gpfc_top u_gpfc_top (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .stat(stat), .pin5_i(pin5_i), .pin5_o(pin5_o),
		.pin5_oe_n(pin5_oe_n), .pin6_i(pin6_i), .pin6_o(pin6_o), .pin6_oe_n(pin6_oe_n),
		.pin6_pullup_en(pu_en), .pin6_pulldown_en(pd_en));

	gpfc_board_model u_gpfc_board_model (.clk(clk), .pin5_o(pin5_o), .pin5_oe_n(pin5_oe_n),
		.pin6_o(pin6_o), .pin6_oe_n(pin6_oe_n), .pin6_pullup_en(pu_en),
		.pin6_pulldown_en(pd_en), .ext5_en(e5_en), .ext5_val(e5_v), .ext6_en(e6_en),
		.ext6_val(e6_v), .pin5_i(pin5_i), .pin6_i(pin6_i));

	// Free-running 200 MHz clock.
	always #2.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Ready is sampled at the falling edge, where it is settled before the taking edge.
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic ta, tw, tb;
		n = 0;
		tb = 1'b0;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!tb && n < 100) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			if (tb) chk("bresp", {30'h0, er}, {30'h0, bresp});
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
			n++;
		end
		if (!tb) chk("bvalid", 32'h1, 32'h0);
	endtask

	task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e, input logic [1:0] er);
		int n;
		logic ta, tr;
		n = 0;
		tr = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!tr && n < 100) begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid;
			if (tr) chk(nm, e & m, rdata & m);
			if (tr) chk("rresp", {30'h0, er}, {30'h0, rresp});
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
			n++;
		end
		if (!tr) chk("rvalid", 32'h1, 32'h0);
	endtask

	// Pins follow registers and status one edge late; three edges leave margin.
	task automatic settle;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	function automatic logic [31:0] p5w(input logic dir, pol, lvl, input logic [4:0] fn);
		return {16'h0, dir, 4'h0, pol, 3'h0, lvl, 1'b0, fn};
	endfunction

	// Routed codes carry a status bit through the polarity; the rest are fixed levels.
	function automatic logic exp_p5(input logic [4:0] fn, input logic lvl, pol,
		input logic [14:0] s);
		int b;
		case (fn)
			5'h02: b = 14;
			5'h03: b = 13;
			5'h04: b = 12;
			5'h06: b = 11;
			5'h07: b = 10;
			5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12: b = 18 - fn;
			default: b = -1;
		endcase
		if (b < 0) begin
			return (fn == 5'h01) ? lvl : 1'b0;
		end
		return s[b] ^ pol;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// A hang is cut short well beyond the thousand or so cycles the tests need.
	initial begin
		#100000;
		fails++;
		end_of_test();
	end

	// Main sequence of tests.
	initial begin
		int k;
		logic pol, lvl, dir, pu, pd, en6, l6;
		logic [4:0] fn;
		logic [14:0] s;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		chk("pin6_oe_n", 32'h1, {31'h0, pin6_oe_n});
		chk("pin6 pulls", 32'h0, {30'h0, pu_en, pd_en});
		rd_chk("pin5 reg", `GPFC_OFS_PIN5, 32'hFFFF, `GPFC_RST_PIN5, 2'h0);
		rd_chk("pin6 reg", `GPFC_OFS_PIN6, 32'hFFFF, `GPFC_RST_PIN6, 2'h0);
		rd_chk("ctrl reg", `GPFC_OFS_CTRL, 32'hFFFF, 32'h0, 2'h0);
		axi_wr(12'h81C, 32'hFFFF, 2'h2);
		rd_chk("unmapped", 12'h81C, 32'hFFFFFFFF, 32'h0, 2'h2);
		axi_wr(`GPFC_OFS_CTRL, 32'h1, 2'h0);
		rd_chk("override", `GPFC_OFS_CTRL, 32'h1, 32'h1, 2'h0);
		// Fifth pin functions are only used once the override is clear again.
		axi_wr(`GPFC_OFS_CTRL, 32'h0, 2'h0);
		$display("Test registers done");
		for (k = 0; k < 2; k++) begin
			e5_v <= k[0];
			repeat (3) @(posedge clk);
			rd_chk("pin5 level", `GPFC_OFS_PIN5, 32'h40, {25'h0, k[0], 6'h0}, 2'h0);
		end
		$display("Test level readback done");
		// Every function code twice, with random status, level and polarity.
		for (k = 0; k < 64; k++) begin
			fn = k[5:1];
			pol = 1'($random(seed));
			lvl = 1'($random(seed));
			s = 15'($random(seed));
			@(posedge clk);
			stat <= gpfc_stat_s'(s);
			axi_wr(`GPFC_OFS_PIN5, p5w(1'b0, pol, lvl, fn), 2'h0);
			settle();
			chk("pin5_oe_n", 32'h0, {31'h0, pin5_oe_n});
			chk("pin5_o", 32'(exp_p5(fn, lvl, pol, s)), 32'(pin5_o));
			s = ~s;
			@(posedge clk);
			stat <= gpfc_stat_s'(s);
			settle();
			chk("pin5_o live", {31'h0, exp_p5(fn, lvl, pol, s)}, {31'h0, pin5_o});
		end
		$display("Test function codes done");
		// Every mix of sixth pin direction, pulls and polarity against a random board.
		for (k = 0; k < 16; k++) begin
			{pol, pd, pu, dir} = k[3:0];
			en6 = 1'($random(seed));
			lvl = 1'($random(seed));
			@(posedge clk);
			e6_en <= en6;
			e6_v <= lvl;
			axi_wr(`GPFC_OFS_PIN6, {16'h0, dir, pu, pd, 2'h0, pol, 10'h0}, 2'h0);
			settle();
			chk("pin6_oe_n", {31'h0, dir}, {31'h0, pin6_oe_n});
			chk("pin6 pulls", {30'h0, pu, pd}, {30'h0, pu_en, pd_en});
			if (!dir) chk("pin6_o", {31'h0, pol}, {31'h0, pin6_o});
			l6 = !dir ? pol : en6 ? lvl : pu;
			if (!dir || en6 || pu || pd) rd_chk("pin6 in", `GPFC_OFS_CTRL, 32'h2,
				{30'h0, l6 ^ pol, 1'b0}, 2'h0);
		end
		$display("Test sixth pin done");
		end_of_test();
	end
endmodule
